// [verilog/branch_pred_pkg.sv]
package branch_pred_pkg;

  // Predictor enable bit position inside system-control coprocessor 15, register 1.
  localparam int unsigned SYS_CTRL_COPROC = 15;
  localparam int unsigned SYS_CTRL_REG = 1;
  localparam int unsigned PRED_ENABLE_BIT = 11;
  localparam logic PRED_ENABLE_RESET = 1'b0;

  // Instruction size in bytes and the sequential step.
  localparam logic [31:0] INSN_STEP = 32'h0000_0004;
  localparam int unsigned INSN_LSB = 2;

  // Branch latency on a misprediction, in core cycles.
  localparam logic [2:0] PENALTY_EARLY = 3'h4;
  localparam logic [2:0] PENALTY_LATE = 3'h5;

  // Pipe geometry.
  localparam int unsigned INT_STAGES = 7;
  localparam int unsigned MEM_STAGES = 8;
  localparam int unsigned MAC_MIN_STAGES = 6;
  localparam int unsigned MAC_MAX_STAGES = 9;
  localparam int unsigned FRONT_STAGES = 5;
  localparam int unsigned MAC_FROM_STAGE = 4;
  localparam int unsigned MAC_UNITS = 4;
  localparam int unsigned MEM_TAIL = 3;

  // History states, ordered from strongly taken down to strongly not taken.
  typedef enum logic [1:0] {
    HIST_STRONG_TAKEN = 2'b11,
    HIST_WEAK_TAKEN = 2'b10,
    HIST_WEAK_NOT_TAKEN = 2'b01,
    HIST_STRONG_NOT_TAKEN = 2'b00
  } hist_t;

  // Instruction class steering it into one of the three pipes.
  typedef enum logic [1:0] {
    KIND_INT = 2'b00,
    KIND_MEM = 2'b01,
    KIND_MAC = 2'b10,
    KIND_NONE = 2'b11
  } kind_t;

endpackage

// [verilog/branch_target_predictor.sv]
`timescale 1ns/1ps

module branch_target_predictor
  import branch_pred_pkg::*;
#(
  parameter int unsigned ENTRIES = 128
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sysctrl_wr,
  input wire logic [31:0] sysctrl_wdata,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic resolve_valid,
  input wire logic [31:0] resolve_addr,
  input wire logic [31:0] resolve_target,
  input wire logic resolve_taken,
  input wire logic resolve_pred_taken,
  input wire logic resolve_late,
  input wire logic issue_valid,
  input wire logic [1:0] issue_kind,
  input wire logic [1:0] issue_mac_len,
  output logic predictor_on,
  output logic pred_valid,
  output logic pred_hit,
  output logic pred_taken,
  output logic [31:0] next_fetch_addr,
  output logic redirect_valid,
  output logic [31:0] redirect_addr,
  output logic flush_busy,
  output logic [INT_STAGES-1:0] int_stage_valid,
  output logic [MEM_TAIL-1:0] mem_stage_valid,
  output logic [MAC_UNITS:0] mac_stage_valid
);

  localparam int unsigned IDX_W = $clog2(ENTRIES);
  localparam int unsigned TAG_LSB = INSN_LSB + IDX_W;
  localparam int unsigned TAG_W = 32 - TAG_LSB;

  generate
    if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES) begin : g_bad_entries
      $error("ENTRIES must be a power of two of at least two");
    end
  endgenerate

  // Entry storage; data words carry no reset because the valid bit guards them.
  logic [TAG_W-1:0] tag_mem [ENTRIES];
  logic [31:0] target_mem [ENTRIES];
  hist_t hist_mem [ENTRIES];
  logic [ENTRIES-1:0] valid_reg;

  logic enable_reg, enable_next;
  logic pv_reg, pv_next;
  logic ph_reg, ph_next;
  logic pt_reg, pt_next;
  logic [31:0] nfa_reg, nfa_next;
  logic rv_reg, rv_next;
  logic [31:0] ra_reg, ra_next;
  logic [2:0] pen_reg, pen_next;
  logic busy_reg, busy_next;

  logic wr_en;
  logic wr_alloc;
  logic [IDX_W-1:0] wr_idx;
  logic [TAG_W-1:0] wr_tag;
  logic [31:0] wr_target;
  hist_t wr_hist;

  logic [IDX_W-1:0] f_idx, r_idx;
  logic f_hit, r_hit;
  hist_t f_hist, r_hist;

  assign f_idx = fetch_addr[TAG_LSB-1:INSN_LSB];
  assign r_idx = resolve_addr[TAG_LSB-1:INSN_LSB];
  assign f_hist = hist_mem[f_idx];
  assign r_hist = hist_mem[r_idx];
  assign f_hit = valid_reg[f_idx] && (tag_mem[f_idx] == fetch_addr[31:TAG_LSB]);
  assign r_hit = valid_reg[r_idx] && (tag_mem[r_idx] == resolve_addr[31:TAG_LSB]);

  // Saturating history step.
  function automatic hist_t hist_step(input hist_t h, input logic taken);
    hist_t r;
    r = h;
    case (h)
      HIST_STRONG_TAKEN: r = taken ? HIST_STRONG_TAKEN : HIST_WEAK_TAKEN;
      HIST_WEAK_TAKEN: r = taken ? HIST_STRONG_TAKEN : HIST_WEAK_NOT_TAKEN;
      HIST_WEAK_NOT_TAKEN: r = taken ? HIST_WEAK_TAKEN : HIST_STRONG_NOT_TAKEN;
      HIST_STRONG_NOT_TAKEN: r = taken ? HIST_WEAK_NOT_TAKEN : HIST_STRONG_NOT_TAKEN;
      default: r = HIST_STRONG_NOT_TAKEN;
    endcase
    return r;
  endfunction

  // Control, lookup and resolution.
  always_comb begin
    enable_next = enable_reg;
    if (sysctrl_wr) begin
      enable_next = sysctrl_wdata[PRED_ENABLE_BIT];
    end

    // Fetch requests arriving during a flush are dropped since the pipe refills anyway.
    pv_next = fetch_valid && !busy_reg;
    ph_next = 1'b0;
    pt_next = 1'b0;
    nfa_next = nfa_reg;
    if (fetch_valid && !busy_reg) begin
      nfa_next = fetch_addr + INSN_STEP;
      if (enable_reg && f_hit) begin
        ph_next = 1'b1;
        if (f_hist[1]) begin
          pt_next = 1'b1;
          nfa_next = target_mem[f_idx];
        end
      end
    end

    wr_en = 1'b0;
    wr_alloc = 1'b0;
    wr_idx = r_idx;
    wr_tag = resolve_addr[31:TAG_LSB];
    wr_target = resolve_target;
    wr_hist = HIST_STRONG_NOT_TAKEN;
    if (resolve_valid && enable_reg) begin
      if (r_hit) begin
        wr_en = 1'b1;
        wr_hist = hist_step(r_hist, resolve_taken);
      end else if (resolve_taken) begin
        wr_en = 1'b1;
        wr_alloc = 1'b1;
        wr_hist = HIST_STRONG_NOT_TAKEN;
      end
    end

    rv_next = 1'b0;
    ra_next = ra_reg;
    pen_next = pen_reg;
    busy_next = busy_reg;
    if (pen_reg != 3'h0) begin
      pen_next = pen_reg - 3'h1;
      busy_next = (pen_reg != 3'h1);
    end
    // A right guess leaves the pipe alone; only a wrong one costs cycles.
    if (resolve_valid && (resolve_taken != resolve_pred_taken)) begin
      rv_next = 1'b1;
      ra_next = resolve_taken ? resolve_target : resolve_addr + INSN_STEP;
      pen_next = resolve_late ? PENALTY_LATE : PENALTY_EARLY;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_reg <= PRED_ENABLE_RESET;
      pv_reg <= 1'b0;
      ph_reg <= 1'b0;
      pt_reg <= 1'b0;
      nfa_reg <= 32'h0000_0000;
      rv_reg <= 1'b0;
      ra_reg <= 32'h0000_0000;
      pen_reg <= 3'h0;
      busy_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      pv_reg <= pv_next;
      ph_reg <= ph_next;
      pt_reg <= pt_next;
      nfa_reg <= nfa_next;
      rv_reg <= rv_next;
      ra_reg <= ra_next;
      pen_reg <= pen_next;
      busy_reg <= busy_next;
    end
  end

  // Allocation overwrites the slot whole, tag and target included.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      hist_mem[wr_idx] <= wr_hist;
      if (wr_alloc) begin
        tag_mem[wr_idx] <= wr_tag;
        target_mem[wr_idx] <= wr_target;
      end
    end
  end

  generate
    for (genvar e = 0; e < ENTRIES; e++) begin : g_valid
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          valid_reg[e] <= 1'b0;
        end else if (wr_alloc && (wr_idx == IDX_W'(e))) begin
          valid_reg[e] <= 1'b1;
        end
      end
    end
  endgenerate

  // Pipe occupancy. Front stages: fetch 1, fetch 2, decode, register/shift, ALU execute.
  logic [FRONT_STAGES-1:0] fv_reg, fv_next;
  kind_t fk_reg [FRONT_STAGES];
  kind_t fk_next [FRONT_STAGES];
  logic [1:0] fl_reg [FRONT_STAGES];
  logic [1:0] fl_next [FRONT_STAGES];
  logic [1:0] isv_reg, isv_next;
  logic [MEM_TAIL-1:0] msv_reg, msv_next;
  logic [MAC_UNITS-1:0] macv_reg, macv_next;
  logic [1:0] macl_reg [MAC_UNITS];
  logic [1:0] macl_next [MAC_UNITS];
  logic mwb_reg, mwb_next;
  logic flush;

  assign flush = rv_next;

  always_comb begin
    fv_next = {fv_reg[FRONT_STAGES-2:0], issue_valid && !busy_reg};
    fk_next[0] = kind_t'(issue_kind);
    fl_next[0] = issue_mac_len;
    for (int s = 1; s < FRONT_STAGES; s++) begin
      fk_next[s] = fk_reg[s-1];
      fl_next[s] = fl_reg[s-1];
    end
    // Multiply ops leave after register/shift, so they never reach ALU execute.
    if (fk_reg[MAC_FROM_STAGE-1] == KIND_MAC) begin
      fv_next[MAC_FROM_STAGE] = 1'b0;
    end
    // A redirect discards the younger work in fetch 1, fetch 2, decode and the new issue; the register/shift op still moves on.
    if (flush) begin
      fv_next[MAC_FROM_STAGE-1:0] = '0;
    end
    isv_next[0] = fv_reg[FRONT_STAGES-1] && (fk_reg[FRONT_STAGES-1] == KIND_INT);
    isv_next[1] = isv_reg[0];
    msv_next[0] = fv_reg[FRONT_STAGES-1] && (fk_reg[FRONT_STAGES-1] == KIND_MEM);
    msv_next[MEM_TAIL-1:1] = msv_reg[MEM_TAIL-2:0];

    macv_next[0] = fv_reg[MAC_FROM_STAGE-1] && (fk_reg[MAC_FROM_STAGE-1] == KIND_MAC);
    macl_next[0] = fl_reg[MAC_FROM_STAGE-1];
    mwb_next = 1'b0;
    for (int m = 1; m < MAC_UNITS; m++) begin
      macv_next[m] = macv_reg[m-1] && (macl_reg[m-1] > 2'(m-1));
      macl_next[m] = macl_reg[m-1];
    end
    // Finished ops in several multiply stages can meet here; they merge into one writeback.
    for (int m = 0; m < MAC_UNITS; m++) begin
      if (macv_reg[m] && (macl_reg[m] == 2'(m))) begin
        mwb_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fv_reg <= '0;
      isv_reg <= '0;
      msv_reg <= '0;
      macv_reg <= '0;
      mwb_reg <= 1'b0;
      for (int s = 0; s < FRONT_STAGES; s++) begin
        fk_reg[s] <= KIND_NONE;
        fl_reg[s] <= 2'h0;
      end
      for (int m = 0; m < MAC_UNITS; m++) begin
        macl_reg[m] <= 2'h0;
      end
    end else begin
      fv_reg <= fv_next;
      isv_reg <= isv_next;
      msv_reg <= msv_next;
      macv_reg <= macv_next;
      mwb_reg <= mwb_next;
      fk_reg <= fk_next;
      fl_reg <= fl_next;
      macl_reg <= macl_next;
    end
  end

  assign predictor_on = enable_reg;
  assign pred_valid = pv_reg;
  assign pred_hit = ph_reg;
  assign pred_taken = pt_reg;
  assign next_fetch_addr = nfa_reg;
  assign redirect_valid = rv_reg;
  assign redirect_addr = ra_reg;
  assign flush_busy = busy_reg;
  assign int_stage_valid = {isv_reg, fv_reg};
  assign mem_stage_valid = msv_reg;
  assign mac_stage_valid = {mwb_reg, macv_reg};

endmodule

// [dv/bp_props.sv]
`timescale 1ns/1ps
module bp_props
  import branch_pred_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sysctrl_wr,
  input wire logic [31:0] sysctrl_wdata,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic resolve_valid,
  input wire logic [31:0] resolve_addr,
  input wire logic [31:0] resolve_target,
  input wire logic resolve_taken,
  input wire logic resolve_pred_taken,
  input wire logic predictor_on,
  input wire logic pred_valid,
  input wire logic pred_hit,
  input wire logic pred_taken,
  input wire logic [31:0] next_fetch_addr,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_addr,
  input wire logic flush_busy,
  input wire logic [INT_STAGES-1:0] int_stage_valid,
  input wire logic [MEM_TAIL-1:0] mem_stage_valid,
  input wire logic [MAC_UNITS:0] mac_stage_valid
);
  logic en_bit;
  logic fetch_ok;
  assign en_bit = sysctrl_wdata[PRED_ENABLE_BIT];
  assign fetch_ok = fetch_valid && !flush_busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_enable_write: assert property (sysctrl_wr |=> predictor_on == $past(en_bit))
    else $error("enable not taken from write");
  a_lookup_answer: assert property (fetch_ok |=> pred_valid)
    else $error("lookup not answered");
  a_seq_fetch: assert property (pred_valid && !pred_taken |->
    next_fetch_addr == $past(fetch_addr) + INSN_STEP)
    else $error("sequential address wrong");
  a_hit_needs_on: assert property (pred_hit |-> pred_valid && $past(predictor_on))
    else $error("hit while disabled");
  a_taken_hit: assert property (pred_taken |-> pred_hit)
    else $error("taken without hit");
  a_no_penalty: assert property (resolve_valid && resolve_taken == resolve_pred_taken
    |=> !redirect_valid)
    else $error("penalty on correct prediction");
  a_redirect_addr: assert property (redirect_valid |-> $past(resolve_valid) &&
    redirect_addr == ($past(resolve_taken) ? $past(resolve_target)
    : $past(resolve_addr) + INSN_STEP))
    else $error("redirect wrong");
  a_flush_min: assert property (redirect_valid |-> flush_busy [*4])
    else $error("flush too short");
  a_flush_max: assert property (redirect_valid ##1 !redirect_valid [*5] |-> !flush_busy)
    else $error("flush too long");
  a_mem_after_alu: assert property (mem_stage_valid[0] |-> $past(int_stage_valid[4]))
    else $error("memory pipe order");
  a_mac_after_rf: assert property (mac_stage_valid[0] |-> $past(int_stage_valid[3]))
    else $error("multiply pipe order");
  a_flush_clears: assert property (redirect_valid |-> int_stage_valid[3:0] == 4'h0)
    else $error("front stages not flushed");
  a_fetch_refused: assert property (fetch_valid && flush_busy |=> !pred_valid)
    else $error("lookup answered during flush");
  c_taken: cover property (pred_taken);
  c_flush: cover property (redirect_valid);
  c_mac_wb: cover property (mac_stage_valid[MAC_UNITS]);
  c_mem_wb: cover property (mem_stage_valid[MEM_TAIL-1]);
endmodule
bind branch_target_predictor bp_props u_props (.clk, .reset, .sysctrl_wr, .sysctrl_wdata,
  .fetch_valid, .fetch_addr, .resolve_valid, .resolve_addr, .resolve_target, .resolve_taken,
  .resolve_pred_taken, .predictor_on, .pred_valid, .pred_hit, .pred_taken, .next_fetch_addr,
  .redirect_valid, .redirect_addr, .flush_busy, .int_stage_valid, .mem_stage_valid,
  .mac_stage_valid);

// [dv/issue_model.sv]
`timescale 1ns/1ps
module issue_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [1:0] len,
  output logic issue_valid,
  output logic [1:0] issue_kind,
  output logic [1:0] issue_mac_len
);
  // Between issues the qualifiers toggle, so a stale class can never pass for a request.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      issue_valid <= 1'b0;
      issue_kind <= 2'h0;
      issue_mac_len <= 2'h0;
    end else begin
      issue_valid <= go;
      issue_kind <= go ? kind : ~issue_kind;
      issue_mac_len <= go ? len : ~issue_mac_len;
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import branch_pred_pkg::*;
  logic clk = 1'b0, reset = 1'b1, sysctrl_wr = 1'b0, fetch_valid = 1'b0, resolve_valid = 1'b0;
  logic resolve_taken = 1'b0, resolve_pred_taken = 1'b0, resolve_late = 1'b0, go = 1'b0;
  logic [31:0] sysctrl_wdata = 32'h0, fetch_addr = 32'h0, resolve_addr = 32'h0;
  logic [31:0] resolve_target = 32'h0, next_fetch_addr, redirect_addr;
  logic [1:0] go_kind = 2'h0, go_len = 2'h0, issue_kind, issue_mac_len;
  logic issue_valid, predictor_on, pred_valid, pred_hit, pred_taken, redirect_valid, flush_busy;
  logic [INT_STAGES-1:0] int_stage_valid;
  logic [MEM_TAIL-1:0] mem_stage_valid;
  logic [MAC_UNITS:0] mac_stage_valid;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  branch_target_predictor uut (.clk, .reset, .sysctrl_wr, .sysctrl_wdata, .fetch_valid,
    .fetch_addr, .resolve_valid, .resolve_addr, .resolve_target, .resolve_taken,
    .resolve_pred_taken, .resolve_late, .issue_valid, .issue_kind, .issue_mac_len,
    .predictor_on, .pred_valid, .pred_hit, .pred_taken, .next_fetch_addr, .redirect_valid,
    .redirect_addr, .flush_busy, .int_stage_valid, .mem_stage_valid, .mac_stage_valid);
  issue_model model_i (.clk, .reset, .go, .kind(go_kind), .len(go_len), .issue_valid,
    .issue_kind, .issue_mac_len);
  initial begin
    forever #50 clk = ~clk;
  end
  // The ceiling sits well above the fewer than two hundred cycles the tests need.
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic set_on(input logic on);
    @(posedge clk);
    sysctrl_wr <= 1'b1;
    sysctrl_wdata <= 32'(on) << PRED_ENABLE_BIT;
    @(posedge clk);
    sysctrl_wr <= 1'b0;
    #1;
    chk_bit(predictor_on, on);
  endtask
  task automatic look(input logic [31:0] a, input logic hit, input logic tk);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a;
    #1;
    chk_bit(pred_valid, 1'b1);
    chk_bit(pred_hit, hit);
    chk_bit(pred_taken, tk);
    chk_word(next_fetch_addr, tk ? a ^ 32'h0000_8000 : a + INSN_STEP);
  endtask
  // Targets are the address with bit 15 flipped, so every expectation follows from the address.
  task automatic res(input logic [31:0] a, input logic tk, input logic ptk, input logic late);
    int n;
    @(posedge clk);
    resolve_valid <= 1'b1;
    resolve_addr <= a;
    resolve_target <= a ^ 32'h0000_8000;
    resolve_taken <= tk;
    resolve_pred_taken <= ptk;
    resolve_late <= late;
    @(posedge clk);
    resolve_valid <= 1'b0;
    resolve_addr <= ~a;
    resolve_target <= a;
    #1;
    n = 0;
    chk_bit(redirect_valid, tk != ptk);
    if (tk != ptk) chk_word(redirect_addr, tk ? a ^ 32'h0000_8000 : a + INSN_STEP);
    while (flush_busy === 1'b1 && n < 9) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk_word(32'(n), (tk == ptk) ? 32'h0 : late ? 32'h5 : 32'h4);
  endtask
  task automatic t_history();
    logic [7:0] tks = 8'h0F;
    logic [7:0] exs = 8'h1E;
    logic prev = 1'b0;
    res(32'h1040, 1'b0, 1'b0, 1'b0);
    look(32'h1040, 1'b0, 1'b0);
    res(32'h1040, 1'b1, 1'b0, 1'b1);
    look(32'h1040, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      res(32'h1040, tks[i], prev, 1'b0);
      look(32'h1040, 1'b1, exs[i]);
      prev = exs[i];
    end
    res(32'h1240, 1'b1, 1'b0, 1'b0);
    look(32'h1040, 1'b0, 1'b0);
    look(32'h1240, 1'b1, 1'b0);
    res(32'h41FC, 1'b1, 1'b0, 1'b0);
    look(32'h41FC, 1'b1, 1'b0);
    $display("history test done");
  endtask
  task automatic t_disabled();
    set_on(1'b0);
    look(32'h1240, 1'b0, 1'b0);
    res(32'h2080, 1'b1, 1'b0, 1'b0);
    set_on(1'b1);
    look(32'h2080, 1'b0, 1'b0);
    $display("disabled test done");
  endtask
  task automatic pipe(input logic [1:0] k, input logic [1:0] l, input logic [31:0] exp);
    int n;
    @(posedge clk);
    go <= 1'b1;
    go_kind <= k;
    go_len <= l;
    @(posedge clk);
    go <= 1'b0;
    #1;
    n = 0;
    while (int_stage_valid[0] !== 1'b1 && n < 9) begin
      n++;
      @(posedge clk);
      #1;
    end
    n = 0;
    while (((k == KIND_INT) ? int_stage_valid[INT_STAGES-1] : (k == KIND_MEM) ?
        mem_stage_valid[MEM_TAIL-1] : mac_stage_valid[MAC_UNITS]) !== 1'b1 && n < 12) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk_word(32'(n), exp);
  endtask
  task automatic t_pipes();
    pipe(KIND_INT, 2'h0, 32'h6);
    pipe(KIND_MEM, 2'h0, 32'h7);
    for (int l = 0; l < 4; l++) pipe(KIND_MAC, 2'(l), 32'(5 + l));
    $display("pipe test done");
  endtask
  // Issue and fetch stay requested through a mispredict; younger ops must vanish and
  // nothing offered while the flush runs may enter.
  task automatic t_flush();
    @(posedge clk);
    go <= 1'b1;
    go_kind <= KIND_INT;
    fetch_valid <= 1'b1;
    repeat (2) @(posedge clk);
    res(32'h3000, 1'b1, 1'b0, 1'b0);
    chk_word({25'h0, int_stage_valid}, 32'h0);
    @(posedge clk);
    go <= 1'b0;
    fetch_valid <= 1'b0;
    $display("flush test done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_bit(predictor_on, PRED_ENABLE_RESET);
    chk_bit(pred_valid, 1'b0);
    set_on(1'b1);
    t_history();
    t_disabled();
    t_pipes();
    t_flush();
    give_verdict();
  end
endmodule
